// ---- testbench.sv ----
// Testbench: start-up, commands, power-ok loss, trips and shutdown
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import vps_pkg::*;
  logic clk, srst, sup, ps_ok, ps_low, en, pok, serial_vid_clock, serial_vid_data, tlm, tlm_oe_n, done, prev_c, cw, nw;
  logic [1:0] ov, uv, oc, sw, continuous_conduction_mode, hint, pg, lat, sel;
  logic [7:0] core_ref, nb_ref, cur_c, cur_n, code;
  logic [31:0] rnd;
  int n_mismatch, samples_checked;
  // Telemetry wire is pulled high when released
  wire logic svt_w = tlm_oe_n ? 1'b1 : tlm;
  vps_sequencer uut (
    .core_clk_i(clk), .srst_i(srst), .supply_above_uvlo_i(sup),
    .power_stage_sense_ok_i(ps_ok), .power_stage_sense_low_i(ps_low), .enable_i(en),
    .core_sense_in_window_i(cw), .nb_sense_in_window_i(nw), .over_voltage_trip_i(ov),
    .under_voltage_trip_i(uv), .over_current_trip_i(oc), .platform_power_ok_i(pok),
    .serial_vid_clock_i(serial_vid_clock), .serial_vid_data_i(serial_vid_data), .serial_telemetry_o(tlm),
    .serial_telemetry_oe_n_o(tlm_oe_n), .core_ref_code_o(core_ref), .nb_ref_code_o(nb_ref),
    .switching_en_o(sw), .continuous_conduction_mode_o(continuous_conduction_mode), .power_state_hint0_n_o(hint),
    .power_good_o(pg), .protect_latched_o(lat), .voltage_transition_done_o(done)
  );
  vps_svi_master m (.serial_vid_clock_o(serial_vid_clock), .serial_vid_data_o(serial_vid_data), .serial_telemetry_i(svt_w));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic [26:0] pkt(input logic c, input logic n, input logic p,
      input logic [7:0] k, input logic bad);
    return {4'hc, bad, c, n, 2'b00, p, k[7:1], 1'b0, k[0], 8'h80};
  endfunction : pkt
  // New target that differs from both rails
  function automatic logic [7:0] pick(input logic [7:0] c);
    if (c != cur_c && c != cur_n)
      return c;
    if ((c ^ 8'h08) != cur_c && (c ^ 8'h08) != cur_n)
      return c ^ 8'h08;
    return c ^ 8'h04;
  endfunction : pick
  task automatic summarize();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Kinds: 0 core ref, 1 nb ref, 2 power good, 3 done pulse, 4 core ref moved
  task automatic wait_for(input int k, input logic [7:0] v, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(negedge clk);
      if ((k == 0 && core_ref === v) || (k == 1 && nb_ref === v) || (k == 2 && pg === v[1:0])
          || (k == 3 && done === 1'b1) || (k == 4 && core_ref !== v))
        return;
    end
    n_mismatch++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, core_ref, v);
    summarize();
  endtask : wait_for
  initial
  begin
    srst = 1'b1;
    {sup, ps_ok, ps_low, en, pok} = 5'h00;
    {cw, nw} = 2'b11;
    {ov, uv, oc} = 6'h00;
    rnd = 32'he9cc;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    tick(2);
    chk(core_ref, CODE_OFF);
    chk(8'({pg, tlm, tlm_oe_n}), 8'h03);
    {sup, ps_ok} = 2'b11;
    tick(10);
    en = 1'b1;
    tick(20);
    chk(8'({continuous_conduction_mode, tlm_oe_n, svt_w}), 8'h0d);
    wait_for(0, CODE_0V80, 70000);
    chk(nb_ref, CODE_0V80);
    chk(8'(pg), 8'h00);
    nw = 1'b0;
    wait_for(2, 8'h01, 26000);
    nw = 1'b1;
    wait_for(2, 8'h03, 20);
    pok = 1'b1;
    tick(10);
    cur_c = CODE_0V80;
    cur_n = CODE_0V80;
    m.send(pkt(1'b1, 1'b0, 1'b1, 8'h70, 1'b1));
    tick(300);
    chk(core_ref, cur_c);
    prev_c = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rnd = xs(rnd);
      sel = (rnd[1:0] == 2'b00) ? 2'b11 : rnd[1:0];
      code = pick(8'h70 | 8'(rnd[5:2]));
      m.send(pkt(sel[0], sel[1], rnd[6], code, 1'b0));
      chk(m.tlm_byte, prev_c ? cur_c : cur_n);
      cur_c = sel[0] ? code : cur_c;
      cur_n = sel[1] ? code : cur_n;
      prev_c = sel[0];
      wait_for(3, 8'h00, 3000);
      chk(core_ref, cur_c);
      chk(nb_ref, cur_n);
      chk(8'(hint[sel[0] ? 0 : 1]), 8'(rnd[6]));
    end
    pok = 1'b0;
    tick(10);
    chk(8'({tlm_oe_n, svt_w}), 8'h01);
    m.send(pkt(1'b1, 1'b1, 1'b1, 8'h7f, 1'b0));
    wait_for(0, CODE_0V80, 10000);
    wait_for(1, CODE_0V80, 10000);
    tick(300);
    chk(core_ref, CODE_0V80);
    rnd = xs(rnd);
    ov[0] = (rnd[1:0] == 2'b00);
    uv[0] = (rnd[1:0] == 2'b01);
    oc[0] = rnd[1];
    tick(2);
    {ov, uv, oc} = 6'h00;
    tick(4);
    chk(8'({lat, pg}), 8'h06);
    tick(1260);
    chk(8'(pg), 8'h00);
    en = 1'b0;
    tick(10);
    chk(8'({lat, pg}), 8'h04);
    wait_for(4, CODE_0V80, 700);
    tick(20);
    sup = 1'b0;
    tick(10);
    chk(8'({lat, sw}), 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire

// ---- vps_pkg.sv ----
// Package: constants and types for the power sequencer with serial voltage-ID slave
`default_nettype none
package vps_pkg;
  // ********************
  // Clock and timing
  // ********************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PG_DELAY_US = 100;
  localparam int unsigned PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
  localparam int unsigned XTRIP_DELAY_US = 5;
  localparam int unsigned XTRIP_DELAY_CYC = XTRIP_DELAY_US * CLK_MHZ;
  localparam int unsigned SVI_READY_MS = 2;
  localparam int unsigned SVI_READY_CYC = SVI_READY_MS * 1000 * CLK_MHZ;
  // Soft-start: 3 mV/us with a 6.25 mV step -> one step every 6.25/3 us
  localparam int unsigned SS_STEP_NS = 2083;
  localparam int unsigned SS_STEP_CYC = (SS_STEP_NS * CLK_MHZ) / 1000;
  // Commanded transition: 12.5 mV/us -> one 6.25 mV step every 0.5 us
  localparam int unsigned VT_STEP_NS = 500;
  localparam int unsigned VT_STEP_CYC = (VT_STEP_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W = 26;
  // ********************
  // Voltage codes (8-bit code, 6.25 mV steps, 0x00 = 1.55 V, higher = lower)
  // ********************
  localparam logic [7:0] CODE_1V10 = 8'h48;
  localparam logic [7:0] CODE_1V00 = 8'h58;
  localparam logic [7:0] CODE_0V90 = 8'h68;
  localparam logic [7:0] CODE_0V80 = 8'h78;
  localparam logic [7:0] CODE_OFF = 8'hf8;
  // Power-good window 300 mV = 48 steps below target
  localparam logic [7:0] PG_WINDOW = 8'h30;
  // Channel stops switching near 0.2 V
  localparam logic [7:0] CODE_0V2 = 8'hd8;
  // ********************
  // Packet layout (bit times 1..27 -> shift index)
  // ********************
  localparam int unsigned PKT_BITS = 27;
  localparam logic [4:0] PKT_HDR = 5'h18;
  localparam int unsigned BIT_PSI0 = 10;
  localparam int unsigned BIT_TFN = 21;
  localparam logic [4:0] PKT_LEN = 5'd27;
  typedef enum logic [2:0] {VPS_OFF, VPS_WAIT_EN, VPS_SOFTSTART, VPS_RUN, VPS_SHUTDOWN,
    VPS_LATCHED} vps_state_t;
endpackage : vps_pkg
`default_nettype wire

// ---- vps_rail_if.sv ----
// Interface: reference ramp control between sequencer and rail ramp modules
`default_nettype none
interface vps_rail_if;
  logic [7:0] target;
  logic fast;
  logic step_en;
  logic [7:0] ref_code;
  logic at_target;
  modport ctrl (output target, output fast, output step_en, input ref_code, input at_target);
  modport rail (input target, input fast, input step_en, output ref_code, output at_target);
endinterface : vps_rail_if
`default_nettype wire

// ---- vps_rail_ramp.sv ----
// Rail reference ramp: steps the code toward a target at the given step rate
`default_nettype none
module vps_rail_ramp
  import vps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Control
  vps_rail_if.rail rif
);
  logic [7:0] ref_r;
  logic [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] period = rif.fast ? CNT_W'(VT_STEP_CYC) : CNT_W'(SS_STEP_CYC);
  wire tick = rif.step_en && (cnt_r >= period - CNT_W'(1));
  assign rif.ref_code = ref_r;
  assign rif.at_target = (ref_r == rif.target);
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !rif.step_en || rif.at_target)
      cnt_r <= '0;
    else if (tick)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CNT_W'(1);
  end
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      ref_r <= CODE_OFF;
    else if (tick && !rif.at_target)
      ref_r <= (ref_r > rif.target) ? ref_r - 8'h01 : ref_r + 8'h01;
  end
endmodule : vps_rail_ramp
`default_nettype wire

// ---- vps_seq_properties.sv ----
// Checker: port-level properties of the power sequencer
`default_nettype none
module vps_seq_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Inputs
  input wire logic supply_above_uvlo_i,
  input wire logic power_stage_sense_ok_i,
  input wire logic enable_i,
  input wire logic platform_power_ok_i,
  input wire logic [1:0] over_voltage_trip_i,
  input wire logic [1:0] under_voltage_trip_i,
  input wire logic [1:0] over_current_trip_i,
  // Outputs
  input wire logic serial_telemetry_o,
  input wire logic [7:0] core_ref_code_o,
  input wire logic [1:0] switching_en_o,
  input wire logic [1:0] continuous_conduction_mode_o,
  input wire logic [1:0] power_good_o,
  input wire logic [1:0] protect_latched_o,
  input wire logic voltage_transition_done_o
);
  import vps_pkg::*;
  wire logic trip0 = over_voltage_trip_i[0] | under_voltage_trip_i[0] | over_current_trip_i[0];
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  // ********************
  // Helper: cycles since a protection latch showed
  // ********************
  // Cross-trip delay plus a small margin, in cycles
  localparam logic [11:0] XT_LATE = 12'h4ec;
  logic [11:0] xt_age_r;
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || protect_latched_o == 2'b00)
      xt_age_r <= 12'h000;
    else if (xt_age_r != 12'hfff)
      xt_age_r <= xt_age_r + 12'h001;
  end
  // ********************
  // Properties
  // ********************
  ready_loss_a: assert property (!supply_above_uvlo_i [*6] |->
    power_good_o == 2'b00 && switching_en_o == 2'b00) else $error("active without power");
  latch_clear_a: assert property (!supply_above_uvlo_i [*6] |-> protect_latched_o == 2'b00)
    else $error("latch kept through power loss");
  latch_hold_a: assert property ((supply_above_uvlo_i && power_stage_sense_ok_i) [*6] ##0
    (|protect_latched_o) |=>
    (|protect_latched_o)) else $error("latch cleared while powered");
  pg_off_a: assert property (!enable_i [*6] |-> power_good_o == 2'b00)
    else $error("power good while disabled");
  ss_step_a: assert property ($changed(core_ref_code_o) && power_good_o == 2'b00 &&
    core_ref_code_o != CODE_OFF |-> core_ref_code_o == $past(core_ref_code_o) + 8'h01 ||
    core_ref_code_o == $past(core_ref_code_o) - 8'h01) else $error("ramp step not one code");
  step_gap_a: assert property ($changed(core_ref_code_o) && core_ref_code_o != CODE_OFF |=>
    $stable(core_ref_code_o) [*8]) else $error("ramp steps too close");
  ss_ccm_a: assert property (enable_i [*6] ##0
    (power_good_o == 2'b00 && protect_latched_o == 2'b00) |->
    continuous_conduction_mode_o == 2'b11) else $error("soft-start not continuous");
  tlm_idle_a: assert property (!platform_power_ok_i [*6] |-> serial_telemetry_o)
    else $error("telemetry low without power ok");
  done_pulse_a: assert property (voltage_transition_done_o |->
    $stable(core_ref_code_o) ##1 !voltage_transition_done_o) else $error("done pulse wrong");
  own_trip_a: assert property (trip0 && power_good_o[0] |-> ##[1:4] !power_good_o[0])
    else $error("trip left power good high");
  cross_trip_a: assert property ($rose(protect_latched_o[0]) && power_good_o[1] |=>
    power_good_o[1] [*8]) else $error("cross trip too early");
  cross_late_a: assert property (xt_age_r == XT_LATE |-> power_good_o == 2'b00)
    else $error("cross trip too late");
endmodule : vps_seq_chk
bind vps_sequencer vps_seq_chk u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .supply_above_uvlo_i(supply_above_uvlo_i),
  .power_stage_sense_ok_i(power_stage_sense_ok_i),
  .enable_i(enable_i), .platform_power_ok_i(platform_power_ok_i),
  .over_voltage_trip_i(over_voltage_trip_i), .under_voltage_trip_i(under_voltage_trip_i),
  .over_current_trip_i(over_current_trip_i), .serial_telemetry_o(serial_telemetry_o),
  .core_ref_code_o(core_ref_code_o), .switching_en_o(switching_en_o),
  .continuous_conduction_mode_o(continuous_conduction_mode_o), .power_good_o(power_good_o),
  .protect_latched_o(protect_latched_o), .voltage_transition_done_o(voltage_transition_done_o)
);
`default_nettype wire

// ---- vps_sequencer.sv ----
// Top: power sequencing, protection, power-good and serial voltage-ID slave
// Functional notes
// - Power-ready only while supply above 4.2V and power-stage sense above 2.2V.
// - Power-ready plus enable starts both rails; code starts only on an enable rise seen while power-ready.
// - Power-ready loss goes straight to off: switching and power-good drop, references hold with no ramp-down.
// - Serial interface ready within 2ms after enable.
// - Protection latches clear only at power-ready low, not at enable low.
// - Sense below 1.5V while regulating shuts down until power-ready cycles.
// - Enable rise latches clock and data lines as two-bit boot code.
// - Soft-start ramps references to boot voltage at 3mV/us in continuous conduction.
// - Power-good asserted after delay once outputs within 300mV of boot.
// - Telemetry line driven high while boot code is taken.
// - Serial interface runs only after platform power-ok rises.
// - Power-ok low stops interface and returns outputs to boot voltage.
// - Valid command ramps to target then signals transition complete.
// - Enable low drops power-good at once, ramps down, stops near 0.2V.
// - Boot code cleared at power-ready reset, resampled next enable.
// - Power-good low when disabled and in soft-start, released per rail.
// - Power-good low on protection trips or enable low.
// - Trip on one rail pulls other power-good low after 5us.
// - Master drives clock and data; device drives only telemetry.
// - Packet is start, three bytes with acknowledges, stop; executed after stop.
// - Header 11000b, domain selects, psi0 hint, code bits 7:1 and 0.
// - Telemetry shifted out on telemetry line, function bit changes content.
// - After power-ok loss telemetry high, clock and data ignored.
// - Commanded transitions step at 12.5mV/us in continuous conduction mode.
`default_nettype none
module vps_sequencer
  import vps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Analog comparator inputs
  input wire logic supply_above_uvlo_i,
  input wire logic power_stage_sense_ok_i,
  input wire logic power_stage_sense_low_i,
  input wire logic enable_i,
  input wire logic core_sense_in_window_i,
  input wire logic nb_sense_in_window_i,
  input wire logic [1:0] over_voltage_trip_i,
  input wire logic [1:0] under_voltage_trip_i,
  input wire logic [1:0] over_current_trip_i,
  input wire logic platform_power_ok_i,
  // Serial voltage-ID link
  input wire logic serial_vid_clock_i,
  input wire logic serial_vid_data_i,
  output logic serial_telemetry_o,
  output logic serial_telemetry_oe_n_o,
  // Rail outputs
  output logic [7:0] core_ref_code_o,
  output logic [7:0] nb_ref_code_o,
  output logic [1:0] switching_en_o,
  output logic [1:0] continuous_conduction_mode_o,
  output logic [1:0] power_state_hint0_n_o,
  output logic [1:0] power_good_o,
  output logic [1:0] protect_latched_o,
  output logic voltage_transition_done_o
);
  import vps_pkg::*;

  // ********************
  // Input synchronisers
  // ********************
  logic [8:0] s1_r, s2_r;
  wire [8:0] raw = {serial_vid_clock_i, serial_vid_data_i, platform_power_ok_i, enable_i,
    supply_above_uvlo_i, power_stage_sense_ok_i, power_stage_sense_low_i,
    core_sense_in_window_i, nb_sense_in_window_i};
  always_ff @(posedge core_clk_i)
  begin
    s1_r <= raw;
    s2_r <= s1_r;
  end
  wire serial_vid_clock = s2_r[8];
  wire serial_vid_data = s2_r[7];
  wire pok = s2_r[6];
  wire en = s2_r[5];
  wire pwr_ready = s2_r[4] && s2_r[3];
  wire dvd_low = s2_r[2];
  wire [1:0] in_win = s2_r[1:0];
  logic svc_d_r, en_d_r;
  always_ff @(posedge core_clk_i)
  begin
    svc_d_r <= serial_vid_clock;
    en_d_r <= en;
  end
  wire svc_rise = serial_vid_clock && !svc_d_r;
  wire svc_fall = !serial_vid_clock && svc_d_r;
  wire en_rise = en && !en_d_r;

  // ********************
  // Sequencer state
  // ********************
  vps_state_t st_r, st_nxt;
  logic [1:0] prot_r;
  logic boot_valid_r;
  logic [1:0] boot_sel_r;
  logic [CNT_W-1:0] pg_cnt_r, rdy_cnt_r;
  logic svi_ready_r;
  wire [1:0] trip_now = over_voltage_trip_i | under_voltage_trip_i | over_current_trip_i;
  wire [7:0] boot_code = (boot_sel_r == 2'b00) ? CODE_1V10 :
    (boot_sel_r == 2'b01) ? CODE_1V00 :
    (boot_sel_r == 2'b10) ? CODE_0V90 : CODE_0V80;

  vps_rail_if core_if();
  vps_rail_if nb_if();
  vps_rail_ramp u_core (.core_clk_i(core_clk_i), .srst_i(srst_i), .rif(core_if));
  vps_rail_ramp u_nb (.core_clk_i(core_clk_i), .srst_i(srst_i), .rif(nb_if));
  wire both_at = core_if.at_target && nb_if.at_target;
  wire both_low = (core_if.ref_code >= CODE_0V2) && (nb_if.ref_code >= CODE_0V2);

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      VPS_OFF: if (pwr_ready) st_nxt = VPS_WAIT_EN;
      VPS_WAIT_EN: if (en_rise) st_nxt = VPS_SOFTSTART;
      VPS_SOFTSTART: if (!en) st_nxt = VPS_SHUTDOWN;
        else if (both_at) st_nxt = VPS_RUN;
      VPS_RUN: if (dvd_low) st_nxt = VPS_LATCHED;
        else if (!en) st_nxt = VPS_SHUTDOWN;
      VPS_SHUTDOWN: if (both_low) st_nxt = VPS_WAIT_EN;
      VPS_LATCHED: st_nxt = VPS_LATCHED;
      default: st_nxt = VPS_OFF;
    endcase
    if (!pwr_ready)
      st_nxt = VPS_OFF;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st_r <= VPS_OFF;
    else
      st_r <= st_nxt;
  end

  // Boot code latch, cleared when power-ready drops
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !pwr_ready)
    begin
      boot_valid_r <= 1'b0;
      boot_sel_r <= 2'b00;
    end
    else if (st_r == VPS_WAIT_EN && en_rise && !boot_valid_r)
    begin
      boot_valid_r <= 1'b1;
      boot_sel_r <= {serial_vid_clock, serial_vid_data};
    end
  end

  // Protection latches: set wins, cleared only by power-ready loss
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      prot_r <= 2'b00;
    else if (st_r == VPS_RUN)
      prot_r <= prot_r | trip_now;
    else if (!pwr_ready)
      prot_r <= 2'b00;
  end

  // Interface ready timer after enable
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || st_r == VPS_OFF || st_r == VPS_WAIT_EN)
    begin
      rdy_cnt_r <= '0;
      svi_ready_r <= 1'b0;
    end
    else if (st_r == VPS_RUN || rdy_cnt_r >= CNT_W'(SVI_READY_CYC - 1))
      svi_ready_r <= 1'b1;
    else
      rdy_cnt_r <= rdy_cnt_r + CNT_W'(1);
  end

  // ********************
  // Serial voltage-ID receiver
  // ********************
  logic [PKT_BITS-1:0] sh_r;
  logic [4:0] bits_r;
  logic in_pkt_r;
  logic [1:0] tgt_sel_r;
  logic [7:0] core_tgt_r, nb_tgt_r;
  logic [1:0] psi_r;
  logic tfn_r, voltage_transition_pend_r, done_r;
  logic [7:0] tel_sh_r;
  logic tel_r;
  logic svd_d_r;
  always_ff @(posedge core_clk_i) svd_d_r <= serial_vid_data;
  wire svd_fall_w = svd_d_r && !serial_vid_data;
  wire svd_rise_w = !svd_d_r && serial_vid_data;
  wire svi_on = pok && svi_ready_r && (st_r == VPS_RUN);
  wire start_c = svi_on && serial_vid_clock && svd_fall_w;
  wire stop_c = svi_on && serial_vid_clock && svd_rise_w;
  // Bit times with acknowledges at 9 and 18; count 27 = complete packet
  wire pkt_ok = (bits_r == PKT_LEN) && (sh_r[PKT_BITS-1 -: 5] == PKT_HDR) && !sh_r[PKT_BITS-8];
  wire [7:0] new_code = {sh_r[PKT_BITS-11 -: 7], sh_r[PKT_BITS-19]};
  wire sel_core = sh_r[PKT_BITS-6];
  wire sel_nb = sh_r[PKT_BITS-7];

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !svi_on)
    begin
      in_pkt_r <= 1'b0;
      bits_r <= '0;
      sh_r <= '0;
    end
    else if (start_c)
    begin
      in_pkt_r <= 1'b1;
      bits_r <= '0;
    end
    else if (stop_c)
      in_pkt_r <= 1'b0;
    else if (in_pkt_r && svc_rise && bits_r < PKT_LEN)
    begin
      sh_r <= {sh_r[PKT_BITS-2:0], serial_vid_data};
      bits_r <= bits_r + 5'd1;
    end
  end

  // Targets: boot code unless a valid command overrides it
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !pok || st_r != VPS_RUN)
    begin
      core_tgt_r <= boot_code;
      nb_tgt_r <= boot_code;
      psi_r <= 2'b11;
      tfn_r <= 1'b0;
      voltage_transition_pend_r <= 1'b0;
    end
    else if (stop_c && in_pkt_r && pkt_ok)
    begin
      if (sel_core) core_tgt_r <= new_code;
      if (sel_nb) nb_tgt_r <= new_code;
      if (sel_core) psi_r[0] <= sh_r[PKT_BITS-BIT_PSI0];
      if (sel_nb) psi_r[1] <= sh_r[PKT_BITS-BIT_PSI0];
      tfn_r <= sh_r[PKT_BITS-BIT_TFN];
      voltage_transition_pend_r <= 1'b1;
    end
    else if (voltage_transition_pend_r && both_at)
      voltage_transition_pend_r <= 1'b0;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      done_r <= 1'b0;
    else
      done_r <= voltage_transition_pend_r && both_at && st_r == VPS_RUN;
  end

  // Telemetry: voltage codes (or all-ones when function bit set), out on clock fall
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !svi_on)
    begin
      tel_r <= 1'b1;
      tel_sh_r <= 8'hff;
    end
    else if (start_c)
      tel_sh_r <= tfn_r ? 8'hff : (sel_core ? core_if.ref_code : nb_if.ref_code);
    else if (svc_fall)
    begin
      tel_r <= tel_sh_r[7];
      tel_sh_r <= {tel_sh_r[6:0], 1'b1};
    end
  end

  // ********************
  // Rail control
  // ********************
  wire ramp_up = (st_r == VPS_SOFTSTART) || (st_r == VPS_RUN);
  assign core_if.target = (st_r == VPS_RUN) ? core_tgt_r : ramp_up ? boot_code : CODE_OFF;
  assign nb_if.target = (st_r == VPS_RUN) ? nb_tgt_r : ramp_up ? boot_code : CODE_OFF;
  assign core_if.fast = (st_r == VPS_RUN);
  assign nb_if.fast = (st_r == VPS_RUN);
  assign core_if.step_en = ramp_up || (st_r == VPS_SHUTDOWN);
  assign nb_if.step_en = core_if.step_en;

  // Power-good: window check after delay, cross-rail trip after 5 us
  logic [CNT_W-1:0] xt_cnt_r;
  logic [1:0] pg_r;
  wire [1:0] in_win_fixed = {nb_if.ref_code <= nb_tgt_r + PG_WINDOW && in_win[0],
    core_if.ref_code <= core_tgt_r + PG_WINDOW && in_win[1]};
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || st_r != VPS_RUN)
      pg_cnt_r <= '0;
    else if (pg_cnt_r < CNT_W'(PG_DELAY_CYC))
      pg_cnt_r <= pg_cnt_r + CNT_W'(1);
  end
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || prot_r == 2'b00)
      xt_cnt_r <= '0;
    else if (xt_cnt_r < CNT_W'(XTRIP_DELAY_CYC))
      xt_cnt_r <= xt_cnt_r + CNT_W'(1);
  end
  wire xt_hit = xt_cnt_r >= CNT_W'(XTRIP_DELAY_CYC);
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || st_r != VPS_RUN || !en)
      pg_r <= 2'b00;
    else if (pg_cnt_r >= CNT_W'(PG_DELAY_CYC))
      pg_r <= in_win_fixed & ~prot_r & ~trip_now & ~{2{xt_hit}};
  end

  // ********************
  // Outputs
  // ********************
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      core_ref_code_o <= CODE_OFF;
      nb_ref_code_o <= CODE_OFF;
      switching_en_o <= 2'b00;
      continuous_conduction_mode_o <= 2'b11;
      power_state_hint0_n_o <= 2'b11;
      power_good_o <= 2'b00;
      protect_latched_o <= 2'b00;
      voltage_transition_done_o <= 1'b0;
      serial_telemetry_o <= 1'b1;
      serial_telemetry_oe_n_o <= 1'b1;
    end
    else
    begin
      core_ref_code_o <= core_if.ref_code;
      nb_ref_code_o <= nb_if.ref_code;
      switching_en_o[0] <= ramp_up || (st_r == VPS_SHUTDOWN && core_if.ref_code < CODE_0V2);
      switching_en_o[1] <= ramp_up || (st_r == VPS_SHUTDOWN && nb_if.ref_code < CODE_0V2);
      continuous_conduction_mode_o <= (voltage_transition_pend_r || st_r != VPS_RUN) ? 2'b11 : psi_r;
      power_state_hint0_n_o <= psi_r;
      power_good_o <= pg_r;
      protect_latched_o <= prot_r;
      voltage_transition_done_o <= done_r;
      serial_telemetry_o <= tel_r;
      serial_telemetry_oe_n_o <= !(pwr_ready && st_r != VPS_OFF);
    end
  end
endmodule : vps_sequencer
`default_nettype wire

// ---- vps_svi_master.sv ----
// Partner: behavioural serial voltage-ID bus master
`default_nettype none
module vps_svi_master (
  // Master lines
  output var logic serial_vid_clock_o,
  output var logic serial_vid_data_o,
  // Telemetry wire
  input wire logic serial_telemetry_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 80;
  localparam int QTR = 40;
  logic [7:0] tlm_byte;
  // Idle high on both lines, also the boot code 11 at enable rise
  initial
  begin
    serial_vid_clock_o = 1'b1;
    serial_vid_data_o = 1'b1;
    tlm_byte = 8'h00;
  end
  // One frame; clock stands high outside frames
  task automatic send(input logic [26:0] pkt);
    #HALF serial_vid_data_o = 1'b0;
    for (int i = 26; i >= 0; i--)
    begin
      #HALF serial_vid_clock_o = 1'b0;
      // Data moves only mid-low phase, clear of any clock edge
      #QTR serial_vid_data_o = pkt[i];
      #QTR serial_vid_clock_o = 1'b1;
      if (i > 18)
        tlm_byte = {tlm_byte[6:0], serial_telemetry_i};
    end
    #HALF serial_vid_clock_o = 1'b0;
    #QTR serial_vid_data_o = 1'b0;
    #QTR serial_vid_clock_o = 1'b1;
    #HALF serial_vid_data_o = 1'b1;
    #HALF;
  endtask : send
endmodule : vps_svi_master
`default_nettype wire
